/* verilog/pmc_mode_ctrl.sv */
// Privilege level, execution mode, stack select and access checks
//
// Summary of operation
// - Only privileged handler, privileged thread, user thread
// - Exception runs handler privileged; otherwise thread mode
// - User level protected access raises fault
// - Privileged level never raises privilege fault
// - Separate main and process stack pointers
// - Decode only 16-bit and 32-bit compact encodings
// - Reject switch to legacy full-width set
// - SRAM bit-band alias gives atomic bit access
// - Unaligned data accesses are accepted
// - 4 GB map, separate code/data/peripheral buses
// - Low external reset pin resets the core
// - Process stack only in user thread mode
// - Control bit 0 selects thread level
// - Stack-select bit stays zero in handler
`default_nettype none
module pmc_mode_ctrl
	import pmc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic external_reset_pin_n_i,
	input wire logic exc_enter_i,
	input wire logic exc_return_i,
	input wire logic ctl_wr_i,
	input wire logic [1:0] ctl_wdata_i,
	input wire logic [1:0] acc_kind_i,
	input wire logic [15:0] insn_hw_i,
	input wire logic insn_valid_i,
	input wire logic legacy_switch_i,
	input wire logic daccess_i,
	input wire logic [31:0] daddr_i,
	input wire logic [1:0] dsize_i,
	input wire logic sp_wr_i,
	input wire logic [31:0] sp_wdata_i,
	output logic core_rst_o,
	output logic privileged_o,
	output logic handler_mode_o,
	output logic [1:0] control_o,
	output logic fault_o,
	output logic [1:0] insn_len_o,
	output logic [1:0] bus_sel_o,
	output logic bitband_o,
	output logic [31:0] bitband_word_o,
	output logic [4:0] bitband_bit_o,
	output logic unaligned_o,
	output logic [31:0] main_stack_pointer_o,
	output logic [31:0] process_stack_pointer_o,
	output logic [31:0] sp_o
);

	////////////////////////////////////////////////////////////////////////
	// Reset pin synchroniser
	logic rst_meta;
	logic rst_sync;
	logic rst_all;
	logic next_rst_meta;
	logic next_rst_sync;

	always_comb begin
		next_rst_meta = ~external_reset_pin_n_i;
		next_rst_sync = rst_meta;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rst_meta <= 1'b1;
			rst_sync <= 1'b1;
		end else begin
			rst_meta <= next_rst_meta;
			rst_sync <= next_rst_sync;
		end
	end

	// Pin asserts reset into the core logic too
	assign rst_all = sys_rst_i | rst_sync;

	////////////////////////////////////////////////////////////////////////
	// Operating state
	pmc_state_t state;
	pmc_state_t next_state;
	logic [1:0] ctl;
	logic [1:0] next_ctl;
	logic in_handler;
	logic use_process;

	always_comb begin
		next_state = state;
		next_ctl = ctl;
		if (ctl_wr_i) begin
			next_ctl = ctl_wdata_i;
		end
		case (state)
			PMC_ST_PRIV_THREAD, PMC_ST_USER_THREAD: begin
				if (exc_enter_i) begin
					next_state = PMC_ST_PRIV_HANDLER;
				end else if (next_ctl[PMC_CTL_LVL_BIT]) begin
					next_state = PMC_ST_USER_THREAD;
				end else begin
					next_state = PMC_ST_PRIV_THREAD;
				end
			end
			PMC_ST_PRIV_HANDLER: begin
				next_ctl[PMC_CTL_STK_BIT] = 1'b0;
				if (exc_return_i && !exc_enter_i) begin
					next_state = next_ctl[PMC_CTL_LVL_BIT] ?
						PMC_ST_USER_THREAD : PMC_ST_PRIV_THREAD;
				end
			end
			default: begin
				next_state = PMC_ST_PRIV_THREAD;
			end
		endcase
		if (next_state == PMC_ST_PRIV_HANDLER) begin
			next_ctl[PMC_CTL_STK_BIT] = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_all) begin
		if (rst_all) begin
			state <= PMC_ST_PRIV_THREAD;
			ctl <= PMC_CTL_RST;
		end else begin
			state <= next_state;
			ctl <= next_ctl;
		end
	end

	assign in_handler = (next_state == PMC_ST_PRIV_HANDLER);
	assign use_process = !in_handler && next_ctl[PMC_CTL_STK_BIT] &&
		next_ctl[PMC_CTL_LVL_BIT];

	////////////////////////////////////////////////////////////////////////
	// Stack pointers
	pmc_stack_bank u_stack (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(rst_all),
		.use_process_i(use_process),
		.wr_en_i(sp_wr_i),
		.wr_data_i(sp_wdata_i),
		.main_stack_pointer_o(main_stack_pointer_o),
		.process_stack_pointer_o(process_stack_pointer_o),
		.sp_o(sp_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Access checks and decode
	logic user_lvl;
	logic next_fault;
	logic [1:0] next_len;
	logic [1:0] next_bus;
	logic next_bb;
	logic [31:0] next_bb_word;
	logic [4:0] next_bb_bit;
	logic next_unal;
	logic r_priv;
	logic r_hand;
	logic r_fault;
	logic [1:0] r_len;
	logic [1:0] r_bus;
	logic r_bb;
	logic [31:0] r_bb_word;
	logic [4:0] r_bb_bit;
	logic r_unal;
	logic [31:0] bb_off;

	assign user_lvl = (state == PMC_ST_USER_THREAD);
	assign bb_off = daddr_i - PMC_SRAM_BB_LO;

	always_comb begin
		next_fault = 1'b0;
		if (user_lvl && (acc_kind_i != PMC_ACC_NONE)) begin
			next_fault = 1'b1;
		end
		if (legacy_switch_i) begin
			next_fault = 1'b1;
		end
		// Privileged states only fault on legacy switch
		if (!user_lvl && !legacy_switch_i) begin
			next_fault = 1'b0;
		end
		next_len = r_len;
		if (insn_valid_i) begin
			if (insn_hw_i[15:11] == 5'h1D || insn_hw_i[15:11] == 5'h1E ||
				insn_hw_i[15:11] == 5'h1F) begin
				next_len = PMC_ILEN_32;
			end else begin
				next_len = PMC_ILEN_16;
			end
		end
		if (daddr_i >= PMC_SYS_BASE || daddr_i >= PMC_PERI_BASE) begin
			next_bus = PMC_BUS_PERI;
		end else if (daddr_i >= PMC_SRAM_BASE) begin
			next_bus = PMC_BUS_DATA;
		end else begin
			next_bus = PMC_BUS_CODE;
		end
		next_bb = daccess_i && daddr_i >= PMC_SRAM_BB_LO &&
			daddr_i <= PMC_SRAM_BB_HI;
		next_bb_word = PMC_SRAM_BB_ROOT + {12'h000, bb_off[24:7], 2'h0};
		next_bb_bit = bb_off[6:2];
		next_unal = 1'b0;
		if (daccess_i) begin
			case (dsize_i)
				2'h1: next_unal = daddr_i[0];
				2'h2: next_unal = |daddr_i[1:0];
				default: next_unal = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_all) begin
		if (rst_all) begin
			r_priv <= 1'b1;
			r_hand <= 1'b0;
			r_fault <= 1'b0;
			r_len <= PMC_ILEN_BAD;
			r_bus <= PMC_BUS_CODE;
			r_bb <= 1'b0;
			r_bb_word <= PMC_SRAM_BB_ROOT;
			r_bb_bit <= 5'h00;
			r_unal <= 1'b0;
			core_rst_o <= 1'b1;
		end else begin
			r_priv <= next_state != PMC_ST_USER_THREAD;
			r_hand <= in_handler;
			r_fault <= next_fault;
			r_len <= next_len;
			r_bus <= next_bus;
			r_bb <= next_bb;
			r_bb_word <= next_bb_word;
			r_bb_bit <= next_bb_bit;
			r_unal <= next_unal;
			core_rst_o <= 1'b0;
		end
	end

	assign privileged_o = r_priv;
	assign handler_mode_o = r_hand;
	assign control_o = ctl;
	assign fault_o = r_fault;
	assign insn_len_o = r_len;
	assign bus_sel_o = r_bus;
	assign bitband_o = r_bb;
	assign bitband_word_o = r_bb_word;
	assign bitband_bit_o = r_bb_bit;
	assign unaligned_o = r_unal;
endmodule : pmc_mode_ctrl
`default_nettype wire

/* include/pmc_pkg.sv */
// Constants and types for the privilege and mode control block
`default_nettype none
package pmc_pkg;
	localparam int PMC_AW = 32;
	localparam int PMC_CTL_W = 2;
	localparam int PMC_CTL_LVL_BIT = 0;
	localparam int PMC_CTL_STK_BIT = 1;
	localparam logic [1:0] PMC_CTL_RST = 2'h0;
	localparam logic [31:0] PMC_SP_RST = 32'h00000000;
	localparam logic [31:0] PMC_SP_ALIGN_MASK = 32'hFFFFFFFC;
	// Address map regions
	localparam logic [31:0] PMC_CODE_BASE = 32'h00000000;
	localparam logic [31:0] PMC_SRAM_BASE = 32'h20000000;
	localparam logic [31:0] PMC_PERI_BASE = 32'h40000000;
	localparam logic [31:0] PMC_SYS_BASE = 32'hE0000000;
	localparam logic [31:0] PMC_SRAM_BB_LO = 32'h22000000;
	localparam logic [31:0] PMC_SRAM_BB_HI = 32'h23FFFFFF;
	localparam logic [31:0] PMC_SRAM_BB_ROOT = 32'h20000000;
	// Instruction widths decoded
	localparam logic [1:0] PMC_ILEN_16 = 2'h1;
	localparam logic [1:0] PMC_ILEN_32 = 2'h2;
	localparam logic [1:0] PMC_ILEN_BAD = 2'h0;
	// Access kinds checked for privilege
	typedef enum logic [1:0] {
		PMC_ACC_NONE,
		PMC_ACC_INSN,
		PMC_ACC_SPECREG,
		PMC_ACC_SYSREG
	} pmc_acc_t;
	typedef enum logic [1:0] {
		PMC_BUS_CODE,
		PMC_BUS_DATA,
		PMC_BUS_PERI
	} pmc_bus_t;
	typedef enum {
		PMC_ST_PRIV_THREAD,
		PMC_ST_USER_THREAD,
		PMC_ST_PRIV_HANDLER
	} pmc_state_t;
endpackage : pmc_pkg
`default_nettype wire

/* verilog/pmc_stack_bank.sv */
// Banked main and process stack pointer storage
`default_nettype none
module pmc_stack_bank
	import pmc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic use_process_i,
	input wire logic wr_en_i,
	input wire logic [31:0] wr_data_i,
	output logic [31:0] main_stack_pointer_o,
	output logic [31:0] process_stack_pointer_o,
	output logic [31:0] sp_o
);
	logic [31:0] msp_q;
	logic [31:0] psp_q;
	logic [31:0] sp_q;
	logic [31:0] next_msp;
	logic [31:0] next_psp;
	logic [31:0] next_sp;

	always_comb begin
		next_msp = msp_q;
		next_psp = psp_q;
		if (wr_en_i) begin
			if (use_process_i) begin
				next_psp = wr_data_i & PMC_SP_ALIGN_MASK;
			end else begin
				next_msp = wr_data_i & PMC_SP_ALIGN_MASK;
			end
		end
		next_sp = use_process_i ? next_psp : next_msp;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			msp_q <= PMC_SP_RST;
			psp_q <= PMC_SP_RST;
			sp_q <= PMC_SP_RST;
		end else begin
			msp_q <= next_msp;
			psp_q <= next_psp;
			sp_q <= next_sp;
		end
	end

	assign main_stack_pointer_o = msp_q;
	assign process_stack_pointer_o = psp_q;
	assign sp_o = sp_q;
endmodule : pmc_stack_bank
`default_nettype wire

/* test/pmc_mode_ctrl_asserts.sv */
// Checker for the privilege and mode control block
`default_nettype none
module pmc_mode_ctrl_asserts
	import pmc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic exc_enter_i,
	input wire logic [1:0] acc_kind_i,
	input wire logic legacy_switch_i,
	input wire logic daccess_i,
	input wire logic [31:0] daddr_i,
	input wire logic [1:0] dsize_i,
	input wire logic core_rst_o,
	input wire logic privileged_o,
	input wire logic handler_mode_o,
	input wire logic [1:0] control_o,
	input wire logic fault_o,
	input wire logic unaligned_o,
	input wire logic [31:0] main_stack_pointer_o,
	input wire logic [31:0] sp_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i || core_rst_o);
	property p_st; !(handler_mode_o && !privileged_o); endproperty
	a_st: assert property (p_st) else $error("user handler");
	property p_ent; exc_enter_i |=> handler_mode_o && privileged_o; endproperty
	a_ent: assert property (p_ent) else $error("entry");
	property p_uf; acc_kind_i != 2'h0 && !privileged_o |=> fault_o; endproperty
	a_uf: assert property (p_uf) else $error("no fault");
	property p_pf; privileged_o && !legacy_switch_i |=> !fault_o; endproperty
	a_pf: assert property (p_pf) else $error("priv fault");
	property p_lg; legacy_switch_i |=> fault_o; endproperty
	a_lg: assert property (p_lg) else $error("legacy");
	property p_ms;
		handler_mode_o || !control_o[1] |-> sp_o == main_stack_pointer_o;
	endproperty
	a_ms: assert property (p_ms) else $error("stack");
	property p_hs; handler_mode_o |-> !control_o[1]; endproperty
	a_hs: assert property (p_hs) else $error("alt stack");
	property p_lv; !handler_mode_o |-> privileged_o == !control_o[0]; endproperty
	a_lv: assert property (p_lv) else $error("level");
	property p_bt;
		$fell(core_rst_o) |-> privileged_o && !handler_mode_o && !control_o;
	endproperty
	a_bt: assert property (p_bt) else $error("boot");
	property p_un;
		daccess_i && dsize_i == 2'h2 && daddr_i[1:0] != 2'h0 |=> unaligned_o;
	endproperty
	a_un: assert property (p_un) else $error("unaligned");
	c_ent: cover property (exc_enter_i ##1 handler_mode_o);
	c_uf: cover property (fault_o && !privileged_o);
	c_un: cover property (unaligned_o);
endmodule : pmc_mode_ctrl_asserts
bind pmc_mode_ctrl pmc_mode_ctrl_asserts u_chk (
	.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .exc_enter_i(exc_enter_i),
	.acc_kind_i(acc_kind_i), .legacy_switch_i(legacy_switch_i),
	.daccess_i(daccess_i), .daddr_i(daddr_i), .dsize_i(dsize_i),
	.core_rst_o(core_rst_o), .privileged_o(privileged_o),
	.handler_mode_o(handler_mode_o), .control_o(control_o),
	.fault_o(fault_o), .unaligned_o(unaligned_o),
	.main_stack_pointer_o(main_stack_pointer_o), .sp_o(sp_o)
);
`default_nettype wire

/* test/test_pmc_mode_ctrl.sv */
// Self-checking bench for the privilege and mode control block
`default_nettype none
module test_pmc_mode_ctrl;
	import pmc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int due; int k; logic [31:0] v;} pmc_note_t;
	logic sys_clk_i = 1'h0, sys_rst_i = 1'h1, external_reset_pin_n_i = 1'h1;
	logic exc_enter_i = 1'h0, exc_return_i = 1'h0, ctl_wr_i = 1'h0;
	logic insn_valid_i = 1'h0, legacy_switch_i = 1'h0, daccess_i = 1'h0;
	logic sp_wr_i = 1'h0;
	logic [1:0] ctl_wdata_i = 2'h0, acc_kind_i = 2'h0, dsize_i = 2'h0;
	logic [15:0] insn_hw_i = 16'h0;
	logic [31:0] daddr_i = 32'h0, sp_wdata_i = 32'h0;
	logic core_rst_o, privileged_o, handler_mode_o, fault_o, bitband_o;
	logic unaligned_o;
	logic [1:0] control_o, insn_len_o, bus_sel_o;
	logic [4:0] bitband_bit_o;
	logic [31:0] bitband_word_o, main_stack_pointer_o;
	logic [31:0] process_stack_pointer_o, sp_o;
	int err_total = 0, tests_run = 0, cyc = 0, i;
	logic [31:0] a, v, bs[5];
	pmc_note_t q[$], n;
	always #2.5 sys_clk_i = ~sys_clk_i;
	pmc_mode_ctrl u_dut (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.external_reset_pin_n_i(external_reset_pin_n_i),
		.exc_enter_i(exc_enter_i), .exc_return_i(exc_return_i),
		.ctl_wr_i(ctl_wr_i), .ctl_wdata_i(ctl_wdata_i),
		.acc_kind_i(acc_kind_i), .insn_hw_i(insn_hw_i),
		.insn_valid_i(insn_valid_i), .legacy_switch_i(legacy_switch_i),
		.daccess_i(daccess_i), .daddr_i(daddr_i), .dsize_i(dsize_i),
		.sp_wr_i(sp_wr_i), .sp_wdata_i(sp_wdata_i), .core_rst_o(core_rst_o),
		.privileged_o(privileged_o), .handler_mode_o(handler_mode_o),
		.control_o(control_o), .fault_o(fault_o), .insn_len_o(insn_len_o),
		.bus_sel_o(bus_sel_o), .bitband_o(bitband_o),
		.bitband_word_o(bitband_word_o), .bitband_bit_o(bitband_bit_o),
		.unaligned_o(unaligned_o), .main_stack_pointer_o(main_stack_pointer_o),
		.process_stack_pointer_o(process_stack_pointer_o), .sp_o(sp_o)
	);
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] obs(input int k);
		case (k)
			0: return 32'(privileged_o);
			1: return 32'(handler_mode_o);
			2: return 32'(control_o);
			3: return 32'(fault_o);
			4: return 32'(insn_len_o);
			5: return 32'(bus_sel_o);
			6: return 32'(bitband_o);
			7: return bitband_word_o;
			8: return 32'(bitband_bit_o);
			9: return 32'(unaligned_o);
			10: return sp_o;
			11: return main_stack_pointer_o;
			12: return process_stack_pointer_o;
			default: return 32'(core_rst_o);
		endcase
	endfunction : obs
	// Pulse bits: sp_wr, daccess, insn, legacy, ctl_wr, return, enter
	task automatic st(input logic [6:0] p, input logic [1:0] wd,
			input logic [1:0] ak, input logic [31:0] d);
		@(posedge sys_clk_i);
		{sp_wr_i, daccess_i, insn_valid_i, legacy_switch_i} <= p[6:3];
		{ctl_wr_i, exc_return_i, exc_enter_i} <= p[2:0];
		ctl_wdata_i <= wd;
		acc_kind_i <= ak;
		insn_hw_i <= d[15:0];
		daddr_i <= d;
		sp_wdata_i <= d;
		dsize_i <= 2'h2;
	endtask : st
	task automatic ex(input int k, input logic [31:0] e);
		q.push_back('{cyc + 2, k, e});
	endtask : ex
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report
	// Outputs settle one edge after the sampling edge
	always @(negedge sys_clk_i) begin
		cyc = cyc + 1;
		while (q.size() > 0 && q[0].due == cyc) begin
			n = q.pop_front();
			tests_run++;
			if (obs(n.k) !== n.v) begin
				err_total++;
				$display("Error out%0d expected %h seen %h", n.k, n.v, obs(n.k));
			end
		end
	end
	initial begin
		repeat (4000) @(posedge sys_clk_i);
		err_total++;
		$display("Error run expected done seen timeout");
		final_report();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(58977));
		bs = '{PMC_CODE_BASE, PMC_SRAM_BASE, PMC_SRAM_BB_LO, PMC_PERI_BASE,
			PMC_SYS_BASE};
		repeat (4) @(posedge sys_clk_i);
		sys_rst_i <= 1'h0;
		// Pin synchroniser keeps the core in reset two more edges
		repeat (3) st(7'h00, 2'h0, 2'h0, 32'h0);
		ex(2, 32'h0);
		ex(13, 32'h0);
		v = $urandom();
		st(7'h40, 2'h0, 2'h3, v);
		ex(11, v & PMC_SP_ALIGN_MASK);
		ex(3, 32'h0);
		st(7'h04, 2'h3, 2'h0, 32'h0);
		ex(0, 32'h0);
		a = $urandom();
		st(7'h40, 2'h0, 2'h0, a);
		ex(10, a & PMC_SP_ALIGN_MASK);
		ex(12, a & PMC_SP_ALIGN_MASK);
		for (i = 1; i < 4; i++) begin
			st(7'h00, 2'h0, 2'(i), 32'h0);
			ex(3, 32'h1);
		end
		st(7'h01, 2'h0, 2'h0, 32'h0);
		ex(2, 32'h1);
		ex(10, v & PMC_SP_ALIGN_MASK);
		ex(1, 32'h1);
		ex(0, 32'h1);
		st(7'h04, 2'h2, 2'h0, 32'h0);
		ex(2, 32'h0);
		st(7'h02, 2'h0, 2'h0, 32'h0);
		ex(1, 32'h0);
		st(7'h08, 2'h0, 2'h0, 32'h0);
		ex(3, 32'h1);
		$display("test modes done");
		for (i = 0; i < 32; i++) begin
			st(7'h10, 2'h0, 2'h0, {16'h0, 5'(i), 11'($urandom())});
			ex(4, 32'(i >= 29 ? PMC_ILEN_32 : PMC_ILEN_16));
		end
		for (i = 0; i < 20; i++) begin
			a = bs[i % 5] + ($urandom() & 32'h00FFFFFF);
			st(7'h20, 2'h0, 2'h0, a);
			ex(5, i % 5 == 0 ? 32'h0 : i % 5 < 3 ? 32'h1 : 32'h2);
			ex(9, 32'(a[1:0] != 2'h0));
			ex(6, 32'(i % 5 == 2));
			if (i % 5 == 2) begin
				ex(7, PMC_SRAM_BB_ROOT + ((a - PMC_SRAM_BB_LO) >> 7 << 2));
				ex(8, 32'(a[6:2]));
			end
		end
		$display("test data done");
		st(7'h04, 2'h1, 2'h0, 32'h0);
		external_reset_pin_n_i <= 1'h0;
		repeat (4) st(7'h00, 2'h0, 2'h0, 32'h0);
		ex(13, 32'h1);
		repeat (4) st(7'h00, 2'h0, 2'h0, 32'h0);
		external_reset_pin_n_i <= 1'h1;
		repeat (5) st(7'h00, 2'h0, 2'h0, 32'h0);
		ex(0, 32'h1);
		ex(2, 32'h0);
		ex(13, 32'h0);
		repeat (3) st(7'h00, 2'h0, 2'h0, 32'h0);
		$display("test pin reset done");
		final_report();
	end
endmodule : test_pmc_mode_ctrl
`default_nettype wire
